/* design/ioc_pin_cell.sv */
`timescale 1ns/100ps
`default_nettype none
module ioc_pin_cell (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic padIn,
  output logic padOut,
  output logic padOeN,
  input wire logic chipResetN,
  input wire logic devOe,
  input wire logic [5:0] dedicatedIn,
  input wire logic [1:0] dedClkPin,
  input wire logic [11:0] rowCellIn,
  input wire logic [11:0] colRouteIn,
  input wire logic coreData,
  input wire logic oeCellIn,
  input wire logic enaCellIn,
  output logic toCore,
  output logic [3:0] globalLine,
  output logic [3:0] blockClk
);

  ioc_pkg::ioc_state_t cur_ff;
  ioc_pkg::ioc_state_t nxt_cur;
  logic [11:0] slotVal;
  logic inPath;
  logic oeSig;
  logic enaSig;
  logic clkSig;
  logic clrUsed;
  logic clrN;
  logic clkEdge;
  logic [1:0] effRole;
  logic regD;
  logic drive;
  logic [15:0] oeChoices;
  logic [15:0] enaChoices;
  logic [15:0] clkChoices;
  logic [15:0] clrChoices;
  logic [1:0] dedClkSensed;

  // Every slot chooses its source; a slot and its partner six apart share a dedicated pin,
  // so both senses of one pin cost two slots.
  genvar gs;
  generate
    for (gs = 0; gs < ioc_pkg::SLOTS; gs++) begin : g_slot
      logic rawSlot;
      ioc_ctrl_select u_src (
        .choices({13'h0000, colRouteIn[gs], rowCellIn[gs], dedicatedIn[gs % ioc_pkg::DEDICATED_PINS]}),
        .sel({2'h0, cur_ff.cfg.slotSrc[2 * gs +: 2]}),
        .picked(rawSlot)
      );
      assign slotVal[gs] = rawSlot ^ cur_ff.cfg.slotInv[gs];
    end
  endgenerate

  // Dedicated clock pins share one sense for all pin cells.
  assign dedClkSensed = dedClkPin ^ {2{cur_ff.cfg.clkInvert}};

  // Role sharing of the twelve slots: output enables on slots zero to five plus two shared ones.
  assign oeChoices = {7'h00, oeCellIn, slotVal[ioc_pkg::SLOT_CE3], slotVal[ioc_pkg::SLOT_CE1],
    slotVal[5:0]};
  assign enaChoices = {8'h00, 1'b1, enaCellIn, slotVal[ioc_pkg::SLOT_CE5:ioc_pkg::SLOT_CE0]};
  assign clkChoices = {12'h000, dedClkSensed, slotVal[ioc_pkg::SLOT_CE5], slotVal[ioc_pkg::SLOT_CE0]};
  assign clrChoices = {14'h0000, slotVal[ioc_pkg::SLOT_CE4], slotVal[ioc_pkg::SLOT_CE2]};

  // Four selectors pull the register controls off the shared bus.
  ioc_ctrl_select u_oe (
    .choices(oeChoices),
    .sel(cur_ff.cfg.oeSel),
    .picked(oeSig)
  );
  ioc_ctrl_select u_ena (
    .choices(enaChoices),
    .sel({1'b0, cur_ff.cfg.enaSel}),
    .picked(enaSig)
  );
  ioc_ctrl_select u_clk (
    .choices(clkChoices),
    .sel({2'h0, cur_ff.cfg.clkSel}),
    .picked(clkSig)
  );
  ioc_ctrl_select u_clr (
    .choices(clrChoices),
    .sel({2'h0, cur_ff.cfg.clrSel}),
    .picked(clrN)
  );

  assign clrUsed = (cur_ff.cfg.clrSel != ioc_pkg::CLR_SEL_NONE);

  // The cell clock is a sampled level; its rising edge is found against last cycle's sample.
  assign clkEdge = clkSig & ~cur_ff.clkPrev;

  // The delay line adds sampling stages so the pad value arrives late, giving zero hold at setup's cost.
  assign inPath = cur_ff.cfg.delayEn ? cur_ff.delayLine[ioc_pkg::DELAY_STAGES - 1] : padIn;

  // A bidirectional pin may only use the cell register for output; input roles on a pin that
  // cannot take them are ignored rather than flagged.
  always_comb begin
    effRole = cur_ff.cfg.role;
    if (cur_ff.cfg.dir == ioc_pkg::DIR_BIDIR && cur_ff.cfg.role == ioc_pkg::ROLE_IN) begin
      effRole = ioc_pkg::ROLE_NONE;
    end
    if (cur_ff.cfg.dir == ioc_pkg::DIR_IN && cur_ff.cfg.role == ioc_pkg::ROLE_OUT) begin
      effRole = ioc_pkg::ROLE_NONE;
    end
    if (cur_ff.cfg.dir == ioc_pkg::DIR_OUT && cur_ff.cfg.role == ioc_pkg::ROLE_IN) begin
      effRole = ioc_pkg::ROLE_NONE;
    end
  end

  assign regD = (effRole == ioc_pkg::ROLE_IN) ? inPath : coreData;

  // Driver decision per direction mode, then the device-wide tri-state on top.
  always_comb begin
    drive = 1'b0;
    unique case (cur_ff.cfg.dir)
      ioc_pkg::DIR_OUT: begin
        drive = 1'b1;
      end
      ioc_pkg::DIR_BIDIR: begin
        drive = oeSig;
      end
      default: begin
        drive = 1'b0;
      end
    endcase
    if (cur_ff.cfg.devOeUse && devOe) begin
      drive = 1'b0;
    end
  end

  // Next-state logic for the whole cell.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.delayLine = {cur_ff.delayLine[0], padIn};
    nxt_cur.clkPrev = clkSig;
    // Device reset wins over clear, enable and clock alike.
    if (!chipResetN || (clrUsed && !clrN)) begin
      nxt_cur.cellQ = 1'b0;
    end else if (clkEdge && enaSig && effRole != ioc_pkg::ROLE_NONE) begin
      nxt_cur.cellQ = regD;
    end
    nxt_cur.padOut = (effRole == ioc_pkg::ROLE_OUT) ? cur_ff.cellQ : coreData;
    nxt_cur.padOeN = ~drive;
    nxt_cur.toCore = (effRole == ioc_pkg::ROLE_IN) ? cur_ff.cellQ : inPath;
    nxt_cur.globalLine = {slotVal[ioc_pkg::SLOT_CE5], slotVal[ioc_pkg::SLOT_CE3], slotVal[ioc_pkg::SLOT_CE1],
      slotVal[ioc_pkg::SLOT_CE0]};
    nxt_cur.blockClk = {ioc_pkg::BLOCKS{dedClkPin[0]}} ^ cur_ff.cfg.blkInv;
    // Writes land in the configuration fields.
    if (wrEn) begin
      unique case (addr)
        ioc_pkg::ADDR_MODE: begin
          nxt_cur.cfg.dir = wrData[1:0];
          nxt_cur.cfg.role = wrData[3:2];
          nxt_cur.cfg.delayEn = wrData[4];
          nxt_cur.cfg.clkInvert = wrData[5];
          nxt_cur.cfg.devOeUse = wrData[6];
        end
        ioc_pkg::ADDR_SEL: begin
          nxt_cur.cfg.oeSel = wrData[3:0];
          nxt_cur.cfg.enaSel = wrData[6:4];
          nxt_cur.cfg.clkSel = wrData[9:8];
          nxt_cur.cfg.clrSel = wrData[11:10];
        end
        ioc_pkg::ADDR_SRC: begin
          nxt_cur.cfg.slotSrc = wrData[23:0];
        end
        ioc_pkg::ADDR_INV: begin
          nxt_cur.cfg.slotInv = wrData[11:0];
        end
        ioc_pkg::ADDR_BLK: begin
          nxt_cur.cfg.blkInv = wrData[3:0];
        end
        default: begin
          nxt_cur.cfg = cur_ff.cfg;
        end
      endcase
    end
    // Read data stand for exactly one cycle; unmapped addresses read zero.
    nxt_cur.rdData = 32'h00000000;
    if (rdEn) begin
      unique case (addr)
        ioc_pkg::ADDR_MODE: begin
          nxt_cur.rdData = {25'h0000000, cur_ff.cfg.devOeUse, cur_ff.cfg.clkInvert, cur_ff.cfg.delayEn,
            cur_ff.cfg.role, cur_ff.cfg.dir};
        end
        ioc_pkg::ADDR_SEL: begin
          nxt_cur.rdData = {20'h00000, cur_ff.cfg.clrSel, cur_ff.cfg.clkSel, 1'b0, cur_ff.cfg.enaSel,
            cur_ff.cfg.oeSel};
        end
        ioc_pkg::ADDR_SRC: begin
          nxt_cur.rdData = {8'h00, cur_ff.cfg.slotSrc};
        end
        ioc_pkg::ADDR_INV: begin
          nxt_cur.rdData = {20'h00000, cur_ff.cfg.slotInv};
        end
        ioc_pkg::ADDR_BLK: begin
          nxt_cur.rdData = {28'h0000000, cur_ff.cfg.blkInv};
        end
        ioc_pkg::ADDR_STATUS: begin
          nxt_cur.rdData = {18'h00000, ~cur_ff.padOeN, cur_ff.cellQ, slotVal};
        end
        default: begin
          nxt_cur.rdData = 32'h00000000;
        end
      endcase
    end
  end

  // Single state register; reset takes constants only.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{cfg: ioc_pkg::CFG_RESET, delayLine: 2'h0, clkPrev: 1'b0, cellQ: 1'b0, padOut: 1'b0,
        padOeN: 1'b1, toCore: 1'b0, globalLine: 4'h0, blockClk: 4'h0, rdData: 32'h00000000};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rdData = cur_ff.rdData;
  assign padOut = cur_ff.padOut;
  assign padOeN = cur_ff.padOeN;
  assign toCore = cur_ff.toCore;
  assign globalLine = cur_ff.globalLine;
  assign blockClk = cur_ff.blockClk;

  // Device reset clears the register whatever the other controls do.
  chk_reset_clears: assert property (@(posedge sys_clk) disable iff (rst)
    !chipResetN |=> !cur_ff.cellQ) else $error("cell register not cleared by device reset");

  // The selected clear forces zero even when a clock edge arrives.
  chk_clear_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (clrUsed && !clrN && clkEdge) |=> !cur_ff.cellQ) else $error("clear lost to clock edge");

  // A captured value equals the data seen at the enabled edge.
  chk_capture_data: assert property (@(posedge sys_clk) disable iff (rst)
    (chipResetN && !(clrUsed && !clrN) && clkEdge && enaSig && effRole != ioc_pkg::ROLE_NONE)
    |=> cur_ff.cellQ == $past(regD)) else $error("cell register missed its data");

  // Without an enabled edge and without clear the register holds.
  chk_hold_value: assert property (@(posedge sys_clk) disable iff (rst)
    (chipResetN && !(clrUsed && !clrN) && !(clkEdge && enaSig)) |=> $stable(cur_ff.cellQ))
    else $error("cell register changed without enabled edge");

  // An enabled device-wide output enable keeps the driver off.
  chk_devoe_off: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.devOeUse && devOe) |=> cur_ff.padOeN) else $error("pin driven under device tri-state");

  // Output-only pins drive unless tri-stated.
  chk_dir_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.dir == ioc_pkg::DIR_OUT && !(cur_ff.cfg.devOeUse && devOe)) ##1
    (cur_ff.cfg.dir == ioc_pkg::DIR_OUT) |-> !cur_ff.padOeN) else $error("output pin not driven");

  // Bidirectional pins pass the input path straight to the core, never through the cell register.
  chk_bidir_path: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.dir == ioc_pkg::DIR_BIDIR) |=> cur_ff.toCore == $past(inPath))
    else $error("bidirectional input went through cell register");

  // Global lines follow their four shared slots one cycle later.
  chk_global_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> cur_ff.globalLine == $past({slotVal[ioc_pkg::SLOT_CE5], slotVal[ioc_pkg::SLOT_CE3],
    slotVal[ioc_pkg::SLOT_CE1], slotVal[ioc_pkg::SLOT_CE0]})) else $error("global line mismatch");

  // With the delay on, the pad reaches the core path three samples late.
  chk_delay_line: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.delayEn && effRole != ioc_pkg::ROLE_IN) [*3] |=> cur_ff.toCore == $past(padIn, 3))
    else $error("delay line latency wrong");

  // With the delay off the pad reaches the core one sample late, for the shortest setup.
  chk_delay_off: assert property (@(posedge sys_clk) disable iff (rst)
    (!cur_ff.cfg.delayEn && effRole != ioc_pkg::ROLE_IN) |=> cur_ff.toCore == $past(padIn))
    else $error("undelayed input path latency wrong");

  // Input-only pins never turn their driver on.
  chk_input_nodrive: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.dir == ioc_pkg::DIR_IN) |=> cur_ff.padOeN)
    else $error("input pin driven");

  // A bidirectional driver follows the selected output enable unless the device tri-state wins.
  chk_bidir_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.dir == ioc_pkg::DIR_BIDIR && !(cur_ff.cfg.devOeUse && devOe))
    |=> cur_ff.padOeN == !$past(oeSig)) else $error("bidirectional driver ignores its enable");

  // The enable from the nearby logic cell becomes the picked output enable when it is selected.
  chk_oe_cell: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_ff.cfg.oeSel == ioc_pkg::OE_SEL_CELL) |-> oeSig == oeCellIn)
    else $error("cell output enable not selected");

  // In the output role the pad is fed from the cell register, not from the core.
  chk_out_register: assert property (@(posedge sys_clk) disable iff (rst)
    (effRole == ioc_pkg::ROLE_OUT) |=> cur_ff.padOut == $past(cur_ff.cellQ))
    else $error("pad not fed by cell register");

  // In the input role the core is fed from the cell register, not from the pad.
  chk_in_register: assert property (@(posedge sys_clk) disable iff (rst)
    (effRole == ioc_pkg::ROLE_IN) |=> cur_ff.toCore == $past(cur_ff.cellQ))
    else $error("core not fed by cell register");

  // Each logic block clock carries its own sense of the first dedicated clock pin.
  chk_block_clock: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> cur_ff.blockClk == $past({ioc_pkg::BLOCKS{dedClkPin[0]}} ^ cur_ff.cfg.blkInv))
    else $error("block clock sense wrong");

  // A clock edge with the enable low leaves the register alone.
  chk_enable_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (chipResetN && !(clrUsed && !clrN) && clkEdge && !enaSig) |=> $stable(cur_ff.cellQ))
    else $error("cell register loaded with enable low");

endmodule
`default_nettype wire

/* design/ioc_pkg.sv */
// What this block does
// - One cell register serves as fast input capture or fast output register.
// - Pin mode is input only, output only or bidirectional.
// - Registered bidirectional pins keep only the output register in the cell.
// - Optional input delay line trades zero hold for longer setup.
// - Clock, clear, enable and output enable come from the shared control bus.
// - Shared bus carries twelve slots: eight enables out, six clock enables, two clocks, two clears.
// - Extra clock and output enables may come from a nearby logic cell.
// - Register may also be clocked from either of two dedicated clock pins.
// - Each slot is fed by a dedicated pin, a row logic cell or column routing.
// - Device-wide reset clears the cell register above every other control.
// - One clock sense applies to dedicated clock pins for every pin cell.
// - Logic block clocks choose true or inverted sense per block.
// - Using both senses of a dedicated input as clocks takes two slots.
// - Both senses of a dedicated input for other controls also take two slots.
// - Slots zero to five are output enables; the rest share roles as tabled.
// - Four slots drive the four device-wide global lines.
// - Enabled device-wide output enable input tri-states the pin driver.
package ioc_pkg;

  localparam int SLOTS = 12;
  localparam int DEDICATED_PINS = 6;
  localparam int GLOBALS = 4;
  localparam int BLOCKS = 4;
  localparam int DELAY_STAGES = 2;

  // Slot roles along the shared bus.
  localparam int SLOT_CE0 = 6;
  localparam int SLOT_CE1 = 7;
  localparam int SLOT_CE2 = 8;
  localparam int SLOT_CE3 = 9;
  localparam int SLOT_CE4 = 10;
  localparam int SLOT_CE5 = 11;

  // Register map, word addresses on the plain port.
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_SEL = 3'h1;
  localparam logic [2:0] ADDR_SRC = 3'h2;
  localparam logic [2:0] ADDR_INV = 3'h3;
  localparam logic [2:0] ADDR_BLK = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;

  localparam logic [1:0] DIR_IN = 2'h0;
  localparam logic [1:0] DIR_OUT = 2'h1;
  localparam logic [1:0] DIR_BIDIR = 2'h2;

  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_IN = 2'h1;
  localparam logic [1:0] ROLE_OUT = 2'h2;

  localparam logic [3:0] OE_SEL_CELL = 4'h8;
  localparam logic [2:0] ENA_SEL_CELL = 3'h6;
  localparam logic [2:0] ENA_SEL_ALWAYS = 3'h7;
  localparam logic [1:0] CLR_SEL_NONE = 2'h2;

  localparam logic [1:0] SRC_DEDICATED = 2'h0;
  localparam logic [1:0] SRC_ROW = 2'h1;
  localparam logic [1:0] SRC_COLUMN = 2'h2;

  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] role;
    logic delayEn;
    logic clkInvert;
    logic devOeUse;
    logic [3:0] oeSel;
    logic [2:0] enaSel;
    logic [1:0] clkSel;
    logic [1:0] clrSel;
    logic [23:0] slotSrc;
    logic [11:0] slotInv;
    logic [3:0] blkInv;
  } ioc_cfg_t;

  typedef struct packed {
    ioc_cfg_t cfg;
    logic [1:0] delayLine;
    logic clkPrev;
    logic cellQ;
    logic padOut;
    logic padOeN;
    logic toCore;
    logic [3:0] globalLine;
    logic [3:0] blockClk;
    logic [31:0] rdData;
  } ioc_state_t;

  localparam ioc_cfg_t CFG_RESET = '{dir: DIR_IN, role: ROLE_NONE, delayEn: 1'b0, clkInvert: 1'b0,
    devOeUse: 1'b0, oeSel: 4'h0, enaSel: ENA_SEL_ALWAYS, clkSel: 2'h0, clrSel: CLR_SEL_NONE,
    slotSrc: 24'h000000, slotInv: 12'h000, blkInv: 4'h0};

endpackage

/* design/ioc_ctrl_select.sv */
`timescale 1ns/100ps
`default_nettype none
// Picks one control bit out of up to sixteen candidates; unused choices must be tied by the caller.
module ioc_ctrl_select (
  input wire logic [15:0] choices,
  input wire logic [3:0] sel,
  output logic picked
);

  // A plain index keeps every control mux identical in timing.
  always_comb begin
    picked = choices[sel];
  end

endmodule
`default_nettype wire

/* sim/ioc_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Board and pad side of one pin cell: resolves the shared pad wire and fans one board clock out.
module ioc_pad_model (
  input wire logic padOut,
  input wire logic padOeN,
  input wire logic extLevel,
  input wire logic boardClk,
  output logic padIn,
  output logic [1:0] dedClkPin
);
  // The pad shows the cell's value while it drives, else whatever the outside circuit holds.
  assign padIn = padOeN ? extLevel : padOut;
  // One board clock goes to both clock pins, true and complement, so both senses exist.
  assign dedClkPin = {~boardClk, boardClk};
endmodule
`default_nettype wire

/* sim/io_element_periph_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module io_element_periph_control_bench;
  logic sys_clk, rst, wrEn, rdEn, padIn, padOut, padOeN, chipResetN, devOe, coreData;
  logic oeCellIn, enaCellIn, toCore, extLevel, boardClk;
  logic [2:0] addr;
  logic [31:0] wrData, rdData, rv, rb;
  logic [5:0] dedicatedIn;
  logic [1:0] dedClkPin;
  logic [11:0] rowCellIn, colRouteIn, inv, se;
  logic [3:0] globalLine, blockClk, hist, blk;
  logic d, q;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  ioc_pin_cell i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
    .chipResetN(chipResetN), .devOe(devOe), .dedicatedIn(dedicatedIn), .dedClkPin(dedClkPin),
    .rowCellIn(rowCellIn), .colRouteIn(colRouteIn), .coreData(coreData), .oeCellIn(oeCellIn),
    .enaCellIn(enaCellIn), .toCore(toCore), .globalLine(globalLine), .blockClk(blockClk));
  ioc_pad_model i_pad (.padOut(padOut), .padOeN(padOeN), .extLevel(extLevel), .boardClk(boardClk),
    .padIn(padIn), .dedClkPin(dedClkPin));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Pad history and hang guard; the ceiling is far above the few hundred cycles used.
  always @(posedge sys_clk) begin
    hist <= {hist[2:0], padIn};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // A gap cycle follows each strobe, so no strobe is assigned twice in one time step.
  task automatic wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge sys_clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge sys_clk);
    rdEn <= 1'b0;
    @(negedge sys_clk);
    v = rdData;
  endtask

  // Expected slot levels before inversion for one source code given to every slot.
  function automatic logic [11:0] slotsExp(input int c);
    logic [11:0] r;
    for (int s = 0; s < 12; s++) begin
      r[s] = (c == 0) ? dedicatedIn[s % 6] : (c == 1) ? rowCellIn[s] : (c == 2) ? colRouteIn[s] : 1'b0;
    end
    return r;
  endfunction

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {rst, wrEn, rdEn, chipResetN, devOe, coreData, oeCellIn, enaCellIn, extLevel, boardClk} = 10'h248;
    {addr, wrData, dedicatedIn, rowCellIn, colRouteIn} = '0;
    void'($urandom(50671));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(3'h6, rv);
    chk("unmapped", rv, 32'h0);
    @(negedge sys_clk);
    chk("rdIdle", rdData, 32'h0);
    rd(ioc_pkg::ADDR_SEL, rv);
    chk("selReset", rv, 32'h870);
    rv = ($urandom & 32'hffffff70) | 32'h9;
    wr(ioc_pkg::ADDR_MODE, rv);
    wr(3'h7, 32'hffffffff);
    rd(ioc_pkg::ADDR_MODE, rb);
    chk("modeRw", rb, rv & 32'h7f);
    // Pad drive per direction, device-wide override and cell-supplied enable.
    for (int m = 0; m < 4; m++) begin
      wr(ioc_pkg::ADDR_MODE, (m == 3) ? 32'h2 : (m == 0) ? 32'h0 : 32'h41);
      wr(ioc_pkg::ADDR_SEL, (m == 3) ? 32'h878 : 32'h870);
      @(posedge sys_clk);
      d = $urandom;
      devOe <= (m == 2);
      oeCellIn <= d;
      coreData <= ~d;
      repeat (3) @(negedge sys_clk);
      chk("padOeN", padOeN, (m == 0 || m == 2) ? 1'b1 : (m == 3) ? 1'(~d) : 1'b0);
      if (m == 1) chk("padPass", padOut, 1'(~d));
    end
    devOe <= 1'b0;
    // Output register clocked by the true pin, then by the complement pin.
    for (int k = 2; k < 4; k++) begin
      wr(ioc_pkg::ADDR_MODE, 32'h9);
      wr(ioc_pkg::ADDR_SEL, 32'h870 | (k << 8));
      d = (k == 3) ? 1'b1 : 1'($urandom);
      boardClk <= (k == 3);
      coreData <= d;
      repeat (3) @(posedge sys_clk);
      boardClk <= ~boardClk;
      repeat (4) @(negedge sys_clk);
      chk("outCapture", padOut, d);
      @(posedge sys_clk);
      coreData <= ~d;
      repeat (4) @(negedge sys_clk);
      chk("outHold", padOut, d);
    end
    @(posedge sys_clk);
    chipResetN <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("chipReset", padOut, 1'b0);
    chipResetN <= 1'b1;
    // Input path with and without the delay line; the far side changes the pad every cycle.
    for (int dl = 0; dl < 2; dl++) begin
      wr(ioc_pkg::ADDR_MODE, dl << 4);
      for (int i = 0; i < 40; i++) begin
        @(posedge sys_clk);
        extLevel <= $urandom;
        @(negedge sys_clk);
        if (i > 4) chk("toCore", toCore, dl ? hist[2] : hist[0]);
      end
    end
    // Every source code on every slot, random inversion, global lines and block clocks.
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      dedicatedIn <= $urandom;
      rowCellIn <= $urandom;
      colRouteIn <= $urandom;
      boardClk <= $urandom;
      inv = $urandom;
      blk = $urandom;
      wr(ioc_pkg::ADDR_SRC, {12{2'(c)}});
      wr(ioc_pkg::ADDR_INV, inv);
      wr(ioc_pkg::ADDR_BLK, blk);
      rd(ioc_pkg::ADDR_STATUS, rv);
      se = slotsExp(c) ^ inv;
      chk("slots", rv[11:0], se);
      chk("globals", globalLine, {se[11], se[9], se[7], se[6]});
      chk("blockClk", blockClk, {4{dedClkPin[0]}} ^ blk);
    end
    // Input register on shared clock a with the cell's own enable and shared clear a, which is active low.
    // Pass one holds the enable low; the last pass clears on a clock edge, so the clear must win.
    @(posedge sys_clk);
    dedicatedIn <= 6'h04;
    wr(ioc_pkg::ADDR_SRC, 32'h0);
    wr(ioc_pkg::ADDR_INV, 32'h0);
    wr(ioc_pkg::ADDR_MODE, 32'h4);
    wr(ioc_pkg::ADDR_SEL, 32'h60);
    for (int j = 0; j < 4; j++) begin
      @(posedge sys_clk);
      d = (j == 2) ? 1'b1 : 1'($urandom);
      extLevel <= d;
      enaCellIn <= (j != 1);
      dedicatedIn <= (j == 3) ? 6'h01 : 6'h05;
      if (j != 1) q = (j == 3) ? 1'b0 : d;
      repeat (3) @(negedge sys_clk);
      chk("inCapture", toCore, q);
      @(posedge sys_clk);
      dedicatedIn <= 6'h04;
    end
    end_of_test();
  end
endmodule
`default_nettype wire
